// ==== logic/chs_map.svh ====
// Constants for the card host status and strobe controller
`ifndef CHS_MAP_SVH
`define CHS_MAP_SVH
// --------------------------------------------------------------
// Modes of the card port
// --------------------------------------------------------------
`define CHS_MODE_MEM 2'h0
`define CHS_MODE_IO 2'h1
`define CHS_MODE_IDE 2'h2
// --------------------------------------------------------------
// Data and FIFO shape
// --------------------------------------------------------------
`define CHS_DATA_W 16
`define CHS_FIFO_DEPTH 8
// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CHS_CLK_PERIOD_NS 5
`define CHS_WE_LOW_NS 30
`define CHS_WE_LOW_CYC ((`CHS_WE_LOW_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_WE_HIGH_NS 20
`define CHS_WE_HIGH_CYC ((`CHS_WE_HIGH_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_CNT_W 4
`endif

// ==== logic/chs_pkg.sv ====
// Types of the card host status and strobe controller
package chs_pkg;
    // Port mode of the card
    typedef logic [1:0] chs_mode_t;
    // Write sequencer states
    typedef enum logic [1:0] {CHS_IDLE, CHS_SETUP, CHS_STROBE, CHS_RECOVER} chs_wr_e;
endpackage

// ==== logic/chs_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module chs_fifo #(
    parameter int WIDTH = 16, // Word width
    parameter int DEPTH = 8 // Word count, power of two
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Async reset, high
    input wire logic [WIDTH-1:0] in_data_i, // Fill data
    input wire logic in_valid_i, // Fill valid
    output logic in_ready_o, // Not full
    output logic [WIDTH-1:0] out_data_o, // Drain data
    output logic out_valid_o, // Not empty
    input wire logic out_ready_i // Drain ready
);
    localparam int AW = $clog2(DEPTH);
    // --------------------------------------------------------------
    // Storage and pointers
    // --------------------------------------------------------------
    logic [WIDTH-1:0] mem_r [DEPTH]; // Word storage
    logic [AW:0] wp_r; // Write pointer, extra wrap bit
    logic [AW:0] rp_r; // Read pointer, extra wrap bit
    logic push; // Word accepted
    logic pop; // Word removed
    assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_r != rp_r;
    assign out_data_o = mem_r[rp_r[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Pointer update; storage has no reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data_i;
        end
    end
endmodule // chs_fifo
`default_nettype wire

// ==== logic/chs_host.sv ====
// Host controller for the card status, strobe and write pins
`timescale 1ns/10ps
`default_nettype none
`include "chs_map.svh"
module chs_host
    import chs_pkg::*;
(
    input wire logic clk_i, // Clock, 200 MHz
    input wire logic rst_i, // Async reset, high
    input wire logic [1:0] mode_i, // Active port mode
    input wire logic udma_i, // Ultra DMA active in IDE mode
    input wire logic wr_valid_i, // Write request
    input wire logic cfg_i, // Write targets configuration space
    output logic wr_ready_o, // Write request taken
    output logic wr_done_o, // Write strobe cycle finished, pulse
    input wire logic [15:0] wr_data_i, // Write data
    output logic [15:0] card_data_o, // Data toward card
    output logic card_data_oe_o, // Data bus drive enable
    output logic card_we_n_o, // Card write strobe, low active
    input wire logic card_wait_n_i, // Card wait / IORDY / ready-to-receive
    input wire logic card_strobe_i, // Card data-out strobe
    input wire logic [15:0] card_data_i, // Data from card
    input wire logic card_wp_i, // Write protect / port width pin
    input wire logic card_ready_i, // Card ready, low while busy
    input wire logic card_vs1_n_i, // First voltage sense
    output logic [15:0] rd_data_o, // Captured strobe word
    output logic rd_valid_o, // Captured word valid
    input wire logic rd_ready_i, // Sink ready
    output logic busy_o, // Card busy or capture FIFO full, access blocked
    output logic hold_o, // Current cycle held by card
    output logic paused_o, // Ultra DMA burst paused
    output logic word_wide_o, // Port or transfer is 16 bits
    output logic wp_done_o, // Memory mode init finished
    output logic low_volt_o // Card readable at low voltage
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [2:0] wt_s1; // First sync stage: wait, strobe, ready
        logic [2:0] wt_s2; // Second stage: wait, strobe, ready
        logic [1:0] wp_s; // Sync chain of the shared pin
        logic [1:0] vs_s; // Sync chain of voltage sense
        logic strb_d; // Previous synced strobe
        logic [15:0] dat_s1; // Data first stage
        logic [15:0] dat_s2; // Data second stage
        chs_wr_e wst; // Write sequencer
        logic [`CHS_CNT_W-1:0] cnt; // Strobe timer
        logic we_n; // Write strobe
        logic oe; // Data drive
        logic [15:0] dout; // Data out
        logic wr_rdy; // Request taken
        logic done; // Write finished
        logic busy; // Card busy or FIFO full
        logic hold; // Cycle held
        logic paused; // Burst paused
        logic wide; // Word wide
        logic wpd; // Write protect done
        logic lv; // Low voltage
        logic [15:0] cap; // Captured word
        logic cap_v; // Captured valid toward FIFO
        logic [15:0] rd_q; // Output word
        logic rd_vq; // Output word valid
    } chs_st_s;
    chs_st_s st_r; // Registered state
    chs_st_s st_nxt; // Next state
    logic fifo_rdy; // FIFO can accept a word
    logic rd_v; // FIFO holds a word
    logic [15:0] rd_d; // FIFO head
    logic pop; // Output register reload
    logic wait_n_q, strobe_q, ready_q; // Synced inputs
    assign wait_n_q = st_r.wt_s2[0];
    assign strobe_q = st_r.wt_s2[1];
    assign ready_q = st_r.wt_s2[2];
    // Cycle count helper, always at least one cycle
    function automatic logic [`CHS_CNT_W-1:0] cyc(input int n);
        return (n < 1) ? `CHS_CNT_W'(1) : `CHS_CNT_W'(n);
    endfunction
    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.wr_rdy = 1'b0;
        // Two flops on every card pin
        st_nxt.wt_s1 = {card_ready_i, card_strobe_i, card_wait_n_i};
        st_nxt.wt_s2 = st_r.wt_s1;
        st_nxt.wp_s = {st_r.wp_s[0], card_wp_i};
        st_nxt.vs_s = {st_r.vs_s[0], card_vs1_n_i};
        st_nxt.dat_s1 = card_data_i;
        st_nxt.dat_s2 = st_r.dat_s1;
        st_nxt.strb_d = strobe_q;
        // FIFO full folded in here so busy_o leaves a flop, one cycle late
        st_nxt.busy = !ready_q || !fifo_rdy;
        // Output word register reload
        if (pop) begin
            st_nxt.rd_q = rd_d;
            st_nxt.rd_vq = 1'b1;
        end else if (rd_ready_i) begin
            st_nxt.rd_vq = 1'b0;
        end
        st_nxt.lv = !st_r.vs_s[1];
        // Wait pin meaning by mode
        st_nxt.hold = (mode_i != `CHS_MODE_IDE || !udma_i) && !wait_n_q;
        st_nxt.paused = (mode_i == `CHS_MODE_IDE) && udma_i &&
                        (!wait_n_q || strobe_q == st_r.strb_d);
        // Shared pin meaning by mode
        st_nxt.wide = (mode_i != `CHS_MODE_MEM) && !st_r.wp_s[1];
        st_nxt.wpd = (mode_i == `CHS_MODE_MEM) && !st_r.wp_s[1] && ready_q;
        // Capture a word on each strobe edge in IDE Ultra DMA only; a word captured while the FIFO is full is dropped
        st_nxt.cap_v = 1'b0;
        if (mode_i == `CHS_MODE_IDE && udma_i && strobe_q != st_r.strb_d) begin
            st_nxt.cap = st_r.dat_s2;
            st_nxt.cap_v = 1'b1;
        end
        // Write sequencer
        unique case (st_r.wst)
            CHS_IDLE: begin
                st_nxt.we_n = 1'b1;
                st_nxt.oe = 1'b0;
                // IDE keeps strobe high; I/O only for configuration
                if (wr_valid_i && ready_q && mode_i != `CHS_MODE_IDE &&
                    (mode_i == `CHS_MODE_MEM || cfg_i)) begin
                    st_nxt.dout = wr_data_i;
                    st_nxt.oe = 1'b1;
                    st_nxt.wr_rdy = 1'b1;
                    st_nxt.wst = CHS_SETUP;
                end
            end
            CHS_SETUP: begin
                st_nxt.we_n = 1'b0;
                st_nxt.cnt = cyc(`CHS_WE_LOW_CYC);
                st_nxt.wst = CHS_STROBE;
            end
            CHS_STROBE: begin
                // Card wait stretches the low phase
                if (st_r.cnt > `CHS_CNT_W'(1)) begin
                    st_nxt.cnt = st_r.cnt - `CHS_CNT_W'(1);
                end else if (wait_n_q) begin
                    st_nxt.we_n = 1'b1;
                    st_nxt.cnt = cyc(`CHS_WE_HIGH_CYC);
                    st_nxt.wst = CHS_RECOVER;
                end
            end
            CHS_RECOVER: begin
                if (st_r.cnt > `CHS_CNT_W'(1)) begin
                    st_nxt.cnt = st_r.cnt - `CHS_CNT_W'(1);
                end else begin
                    st_nxt.oe = 1'b0;
                    st_nxt.done = 1'b1;
                    st_nxt.wst = CHS_IDLE;
                end
            end
        endcase
    end
    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '{wst: CHS_IDLE, we_n: 1'b1, wt_s1: 3'h1, wt_s2: 3'h1, busy: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end
    // --------------------------------------------------------------
    // Captured data buffer
    // --------------------------------------------------------------
    // Overflow is only possible if the sink stalls during a burst
    chs_fifo #(.WIDTH(`CHS_DATA_W), .DEPTH(`CHS_FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(st_r.cap),
        .in_valid_i(st_r.cap_v),
        .in_ready_o(fifo_rdy),
        .out_data_o(rd_d),
        .out_valid_o(rd_v),
        .out_ready_i(pop)
    );
    // Reload when the output word is empty or being taken
    assign pop = rd_v && (!st_r.rd_vq || rd_ready_i);
    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign rd_data_o = st_r.rd_q;
    assign rd_valid_o = st_r.rd_vq;
    assign wr_ready_o = st_r.wr_rdy;
    assign wr_done_o = st_r.done;
    assign card_data_o = st_r.dout;
    assign card_data_oe_o = st_r.oe;
    assign card_we_n_o = st_r.we_n;
    assign busy_o = st_r.busy;
    assign hold_o = st_r.hold;
    assign paused_o = st_r.paused;
    assign word_wide_o = st_r.wide;
    assign wp_done_o = st_r.wpd;
    assign low_volt_o = st_r.lv;
endmodule // chs_host
`default_nettype wire

// ==== test/chs_host_properties.sv ====
// Assertion checker for the card host controller ports
`timescale 1ns/10ps
`default_nettype none
module chs_host_properties (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic [1:0] mode_i, // Mode
    input wire logic cfg_i, // Config write
    input wire logic wr_ready_o, // Taken
    input wire logic wr_done_o, // Done
    input wire logic card_data_oe_o, // Bus drive
    input wire logic card_we_n_o, // Write strobe
    input wire logic card_wait_n_i, // Wait pin
    input wire logic card_wp_i, // Width pin
    input wire logic card_ready_i, // Ready pin
    input wire logic card_vs1_n_i, // Sense pin
    input wire logic busy_o, // Busy
    input wire logic word_wide_o, // Word wide
    input wire logic low_volt_o // Low voltage
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Write taken, then strobe falls next cycle
    sequence s_taken;
        wr_ready_o ##1 !card_we_n_o;
    endsequence
    ide_we_high_a: assert property (mode_i == 2'h2 |-> card_we_n_o) else $error("strobe low in ide");
    we_low_len_a: assert property ($fell(card_we_n_o) |-> !card_we_n_o [*6]) else $error("strobe short");
    write_done_a: assert property (s_taken |-> ##[9:80] wr_done_o) else $error("no done");
    oe_cover_a: assert property (!card_we_n_o |-> card_data_oe_o) else $error("bus not driven");
    take_mode_a: assert property (wr_ready_o |-> $past(mode_i) == 2'h0 ||
        ($past(mode_i) == 2'h1 && $past(cfg_i))) else $error("write in wrong mode");
    wait_hold_a: assert property ((!card_we_n_o && !card_wait_n_i) [*4] |=> !card_we_n_o)
        else $error("strobe ended in wait");
    wide_flag_a: assert property ((!card_wp_i && mode_i != 2'h0) [*5] |-> word_wide_o)
        else $error("width not seen");
    low_volt_a: assert property (!card_vs1_n_i [*5] |-> low_volt_o) else $error("sense missed");
    card_busy_a: assert property (!card_ready_i [*5] |-> busy_o) else $error("busy missed");
endmodule // chs_host_properties
bind chs_host chs_host_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .cfg_i(cfg_i),
    .wr_ready_o(wr_ready_o), .wr_done_o(wr_done_o), .card_data_oe_o(card_data_oe_o),
    .card_we_n_o(card_we_n_o), .card_wait_n_i(card_wait_n_i), .card_wp_i(card_wp_i),
    .card_ready_i(card_ready_i), .card_vs1_n_i(card_vs1_n_i), .busy_o(busy_o),
    .word_wide_o(word_wide_o), .low_volt_o(low_volt_o));
`default_nettype wire

// ==== test/chs_card_model.sv ====
// Behavioural card model facing the host controller
`timescale 1ns/10ps
`default_nettype none
module chs_card_model (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset, high
    input wire logic stall_i, // Bench asks to stretch or pause
    output logic wait_n_o, // Wait / ready handshake
    output logic strobe_o, // Data-out strobe
    output logic [15:0] data_o, // Data toward host
    output logic wp_o, // Protect / width pin
    output logic ready_o, // Low while busy
    output logic vs1_n_o // First voltage sense
);
    int init_cnt; // Init countdown
    // No DMA acknowledge input, so stall acts the same in every mode
    assign vs1_n_o = 1'b0; // Grounded sense
    assign wait_n_o = !stall_i; // Stretch or pause, any mode
    assign wp_o = !ready_o; // Low after init, wide port, word cycle
    assign ready_o = (init_cnt == 0); // Busy until init ends
    // Init countdown restarts at every reset
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_cnt <= 10;
        end else if (init_cnt > 0) begin
            init_cnt <= init_cnt - 1;
        end
    end
    initial begin
        strobe_o = 1'b0;
        data_o = 16'h0000;
    end
    // One word per strobe edge; edges then stop, which pauses
    task automatic burst(input int n, input logic [15:0] base);
        for (int k = 0; k < n; k++) begin
            @(posedge clk_i);
            data_o <= base + 16'(k);
            repeat (2) @(posedge clk_i);
            strobe_o <= ~strobe_o; // Rise and fall both carry
            repeat (2) @(posedge clk_i);
        end
        data_o <= ~(base + 16'(n - 1)); // Stale data not left standing
    endtask
endmodule // chs_card_model
`default_nettype wire

// ==== test/tb_chs_host.sv ====
// Self-checking testbench of the card host controller
`timescale 1ns/10ps
`default_nettype none
module tb_chs_host;
    logic clk_i = 0, rst_i = 1, udma_i = 0, wr_valid_i = 0, cfg_i = 0, rd_ready_i = 0, stall = 0;
    logic [1:0] mode_i = 2'h0;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_ready_o, wr_done_o, card_data_oe_o, card_we_n_o, rd_valid_o, busy_o, hold_o, paused_o;
    logic word_wide_o, wp_done_o, low_volt_o, cwait_n, cstrobe, cwp, cready, cvs1_n;
    logic [15:0] card_data_o, rd_data_o, card_rx, cdat;
    int bad_count = 0, n_compared = 0;
    always #2.5 clk_i = ~clk_i;
    chs_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .udma_i(udma_i),
        .wr_valid_i(wr_valid_i), .cfg_i(cfg_i), .wr_ready_o(wr_ready_o), .wr_done_o(wr_done_o),
        .wr_data_i(wr_data_i), .card_data_o(card_data_o), .card_data_oe_o(card_data_oe_o),
        .card_we_n_o(card_we_n_o), .card_wait_n_i(cwait_n), .card_strobe_i(cstrobe),
        .card_data_i(card_rx), .card_wp_i(cwp), .card_ready_i(cready), .card_vs1_n_i(cvs1_n),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .busy_o(busy_o),
        .hold_o(hold_o), .paused_o(paused_o), .word_wide_o(word_wide_o), .wp_done_o(wp_done_o),
        .low_volt_o(low_volt_o));
    chs_card_model card_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .wait_n_o(cwait_n),
        .strobe_o(cstrobe), .data_o(card_rx), .wp_o(cwp), .ready_o(cready), .vs1_n_o(cvs1_n));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One write attempt; counts strobe-low cycles and catches the bus word
    task automatic do_write(input logic [15:0] d, input logic taken, input int min_low);
        int n, low;
        n = 0;
        low = 0;
        @(posedge clk_i);
        wr_data_i <= d;
        wr_valid_i <= 1'b1;
        // Refused attempts stay short so the card cannot come ready meanwhile
        while (!(wr_ready_o === 1'b1 || n > (taken ? 30 : 6) || (taken && wr_done_o === 1'b1))) begin
            @(negedge clk_i);
            n++;
        end
        check(wr_ready_o, taken);
        @(posedge clk_i);
        wr_valid_i <= 1'b0;
        n = 0;
        while (taken && wr_done_o !== 1'b1 && n < 90) begin
            @(negedge clk_i);
            n++;
            if (card_we_n_o === 1'b0) begin
                low++;
                cdat = card_data_o;
            end
        end
        check(taken ? 16'(low >= min_low) : 16'(card_we_n_o), 16'h0001);
        if (taken) check(cdat, d);
    endtask
    // Card stretches the strobe through its wait pin
    task automatic t_stretch();
        @(posedge clk_i);
        stall <= 1'b1;
        fork
            begin
                repeat (14) @(negedge clk_i);
                check(hold_o, 1'b1);
                @(posedge clk_i);
                stall <= 1'b0;
            end
        join_none
        do_write(16'h5A3C, 1'b1, 12);
    endtask
    // Both-edge burst with the sink stalled until the FIFO is full
    task automatic t_burst();
        int got;
        got = 0;
        @(posedge clk_i);
        mode_i <= 2'h2;
        udma_i <= 1'b1;
        stall <= 1'b1;
        repeat (6) @(negedge clk_i);
        check(paused_o, 1'b1);
        @(posedge clk_i);
        stall <= 1'b0;
        card_u.burst(10, 16'h1230);
        repeat (8) @(negedge clk_i);
        check(paused_o, 1'b1);
        check(busy_o, 1'b1);
        @(posedge clk_i);
        rd_ready_i <= 1'b1;
        repeat (60) begin
            @(negedge clk_i);
            if (rd_valid_o === 1'b1 && got < 8) begin
                check(rd_data_o, 16'h1230 + 16'(got));
                got++;
            end
        end
        check(rd_valid_o, 1'b0);
        check(16'(got), 16'h0008);
    endtask
    initial begin
        #50us;
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check(busy_o, 1'b1);
        do_write(16'h1111, 1'b0, 0);
        repeat (20) @(negedge clk_i);
        check(low_volt_o, 1'b1);
        check(wp_done_o, 1'b1);
        do_write(16'hA5C3, 1'b1, 6);
        t_stretch();
        @(posedge clk_i);
        mode_i <= 2'h1;
        do_write(16'h2222, 1'b0, 0);
        @(posedge clk_i);
        cfg_i <= 1'b1;
        do_write(16'h0F0E, 1'b1, 6);
        check(word_wide_o, 1'b1);
        @(posedge clk_i);
        mode_i <= 2'h2;
        do_write(16'h3333, 1'b0, 0);
        check(word_wide_o, 1'b1);
        t_burst();
        complete_run();
    end
endmodule // tb_chs_host
`default_nettype wire
